// >>> hw/wqs_device.sv
`timescale 1ns/1ps
module wqs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Occupancy
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic push;
  logic pop;

  assign in_ready = level != ($clog2(DEPTH+1))'(DEPTH);
  assign out_valid = level != '0;
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      level <= level + ($clog2(DEPTH+1))'(push) - ($clog2(DEPTH+1))'(pop);
    end
  end
endmodule : wqs_fifo

module wqs_device #(
  parameter int NUM_Q = wqs_pkg::NUM_Q_DEF,
  parameter int QDEPTH = wqs_pkg::QDEPTH_DEF,
  parameter int AF_GAP = wqs_pkg::AF_GAP_DEF,
  parameter int FIFO_DEPTH = wqs_pkg::FIFO_DEPTH_DEF,
  parameter int PROG_CYCLES = wqs_pkg::PROG_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Writer link
  wqs_write_if.device link,
  // Board straps and mode
  input wire logic flag_mode_polled,
  input wire logic [wqs_pkg::DEV_W-1:0] chip_position_pins,
  // Expansion chain
  input wire logic expansion_flag_in,
  output logic expansion_flag_out,
  // Drain port
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [wqs_pkg::QSEL_W-1:0] rd_queue,
  output logic [wqs_pkg::DATA_W-1:0] rd_data
);
  import wqs_pkg::*;

  localparam int CW = $clog2(QDEPTH+1);
  localparam int FW = $clog2(FIFO_DEPTH+1);
  localparam int QUADS_USED = (NUM_Q + FLAG_W - 1) / FLAG_W;
  localparam int PCW = $clog2(PROG_CYCLES+1);

  logic [DEV_W-1:0] pos_meta_reg;
  logic [DEV_W-1:0] pos_reg;
  logic [PCW-1:0] prog_cnt_reg;
  logic prog_done;
  logic dev_match;
  logic [QSEL_W-1:0] pend_q_reg;
  logic pend_vld_reg;
  logic pend_match_reg;
  logic [QSEL_W-1:0] active_q_reg;
  logic active_sel_reg;
  logic [QSEL_W-1:0] act_q_next;
  logic act_sel_next;
  logic [CW-1:0] cnt_reg [NUM_Q];
  logic [CW-1:0] cnt_next [NUM_Q];
  logic write_do;
  logic fifo_in_ready;
  logic pop;
  logic [FW-1:0] fifo_level;
  logic [FW-1:0] fifo_level_next;
  logic [QUAD_W-1:0] dir_quad_reg;
  logic dir_drive_reg;
  logic token_reg;
  logic [QUAD_W-1:0] poll_quad_reg;
  logic [QUAD_W-1:0] show_quad;
  logic [FLAG_W-1:0] quad_bits;
  logic poll_last;

  function automatic logic near_full(input logic [CW-1:0] c);
    return c >= CW'(QDEPTH - AF_GAP);
  endfunction : near_full

  // Position pins come from the board, so they are synchronised first
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pos_meta_reg <= '0;
      pos_reg <= '0;
    end else begin
      pos_meta_reg <= chip_position_pins;
      pos_reg <= pos_meta_reg;
    end
  end

  // Stand-in for configuration time after reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prog_cnt_reg <= PCW'(PROG_CYCLES);
    end else if (prog_cnt_reg != '0) begin
      prog_cnt_reg <= prog_cnt_reg - 1'b1;
    end
  end
  assign prog_done = prog_cnt_reg == '0;
  assign link.serial_program_done_n = !prog_done;

  assign dev_match = link.write_queue_addr_bus[DEV_LSB +: DEV_W] == pos_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pend_vld_reg <= 1'b0;
      pend_match_reg <= 1'b0;
      pend_q_reg <= '0;
    end else begin
      pend_vld_reg <= link.write_addr_strobe;
      if (link.write_addr_strobe) begin
        pend_match_reg <= dev_match;
        pend_q_reg <= link.write_queue_addr_bus[QSEL_LSB +: QSEL_W];
      end
    end
  end

  // selection lands one edge later, so the second edge writes it
  assign act_q_next = pend_vld_reg ? pend_q_reg : active_q_reg;
  assign act_sel_next = pend_vld_reg ? pend_match_reg : active_sel_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      active_q_reg <= '0;
      active_sel_reg <= 1'b0;
    end else begin
      active_q_reg <= act_q_next;
      active_sel_reg <= act_sel_next;
    end
  end

  // chip select and enable both low
  assign write_do = rst_n && active_sel_reg && !link.write_chip_select_n &&
                    !link.write_enable_n && fifo_in_ready &&
                    cnt_reg[active_q_reg] != CW'(QDEPTH);

  wqs_fifo #(
    .WIDTH(QSEL_W + DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(write_do),
    .in_ready(fifo_in_ready),
    .in_data({active_q_reg, link.write_data}),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data({rd_queue, rd_data}),
    .level(fifo_level)
  );
  assign pop = rd_valid && rd_ready;
  assign fifo_level_next = fifo_level + FW'(write_do) - FW'(pop);

  always_comb begin
    for (int i = 0; i < NUM_Q; i++) begin
      cnt_next[i] = cnt_reg[i];
      if (write_do && active_q_reg == QSEL_W'(i)) begin
        cnt_next[i] = CW'(cnt_next[i] + 1'b1);
      end
      if (pop && rd_queue == QSEL_W'(i)) begin
        cnt_next[i] = CW'(cnt_next[i] - 1'b1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_Q; i++) begin
        cnt_reg[i] <= '0;
      end
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // active queue flags on clock
  // Flags look ahead at next counts, so a writer sees them one edge sooner
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      link.active_full_flag <= 1'b0;
      link.active_almost_full_flag <= 1'b0;
    end else begin
      link.active_full_flag <= act_sel_next &&
        (cnt_next[act_q_next] == CW'(QDEPTH) ||
         fifo_level_next == FW'(FIFO_DEPTH));
      link.active_almost_full_flag <= act_sel_next &&
        near_full(cnt_next[act_q_next]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dir_quad_reg <= '0;
      dir_drive_reg <= 1'b0;
    end else if (link.flag_quadrant_strobe) begin
      dir_drive_reg <= dev_match;
      dir_quad_reg <= link.write_queue_addr_bus[QUAD_LSB +: QUAD_W];
    end
  end

  assign poll_last = poll_quad_reg == QUAD_W'(QUADS_USED - 1);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      token_reg <= 1'b0;
      poll_quad_reg <= '0;
      expansion_flag_out <= 1'b0;
    end else begin
      expansion_flag_out <= 1'b0;
      if (!flag_mode_polled) begin
        token_reg <= 1'b0;
        poll_quad_reg <= '0;
      end else if (token_reg) begin
        poll_quad_reg <= poll_last ? '0 : poll_quad_reg + 1'b1;
        if (poll_last) begin
          token_reg <= 1'b0;
          expansion_flag_out <= 1'b1;
        end
      end else if (expansion_flag_in ||
                   (prog_cnt_reg == PCW'(1) && pos_reg == DEV_FIRST)) begin
        token_reg <= 1'b1;
        poll_quad_reg <= '0;
      end
    end
  end

  assign show_quad = flag_mode_polled ? poll_quad_reg : dir_quad_reg;

  // Quadrants past the last queue read as not almost full
  always_comb begin
    quad_bits = '0;
    for (int b = 0; b < FLAG_W; b++) begin
      if (int'(show_quad) * FLAG_W + b < NUM_Q) begin
        quad_bits[b] = near_full(cnt_next[int'(show_quad) * FLAG_W + b]);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      link.almost_full_quadrant_bus <= '0;
      link.almost_full_quadrant_bus_oe_n <= 1'b1;
      link.flag_bus_sync <= 1'b0;
    end else begin
      link.almost_full_quadrant_bus <= quad_bits;
      link.almost_full_quadrant_bus_oe_n <=
        !(flag_mode_polled ? token_reg : dir_drive_reg);
      link.flag_bus_sync <= flag_mode_polled && token_reg &&
                            poll_quad_reg == '0;
    end
  end
endmodule : wqs_device

// >>> hw/wqs_pkg.sv
package wqs_pkg;
  // Link widths
  localparam int DATA_W = 40;
  localparam int ADDR_W = 8;
  localparam int QSEL_W = 5;
  localparam int QUAD_W = 4;
  localparam int DEV_W = 3;
  localparam int FLAG_W = 8;
  // Address field positions
  localparam int DEV_LSB = 5;
  localparam int QSEL_LSB = 0;
  localparam int QUAD_LSB = 0;
  // Sizing defaults
  localparam int NUM_Q_DEF = 32;
  localparam int QDEPTH_DEF = 8;
  localparam int AF_GAP_DEF = 2;
  localparam int FIFO_DEPTH_DEF = 32;
  // Timing counts in write clock cycles
  localparam int PROG_CYCLES_DEF = 16;
  localparam int SEL_GAP = 2;
  localparam int SYNC_STAGES = 2;
  // Reset address value and position of the device that starts the token
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  localparam logic [DEV_W-1:0] DEV_FIRST = 3'h0;
endpackage : wqs_pkg

// >>> hw/wqs_write_if.sv
`timescale 1ns/1ps
interface wqs_write_if
  import wqs_pkg::*;
(
  input wire logic clk_sys
);
  logic write_chip_select_n;
  logic write_enable_n;
  logic [DATA_W-1:0] write_data;
  logic write_addr_strobe;
  logic flag_quadrant_strobe;
  logic [ADDR_W-1:0] write_queue_addr_bus;
  logic [FLAG_W-1:0] almost_full_quadrant_bus;
  logic almost_full_quadrant_bus_oe_n;
  logic active_almost_full_flag;
  logic active_full_flag;
  logic flag_bus_sync;
  logic serial_program_done_n;

  modport device (
    input write_chip_select_n, write_enable_n, write_data,
    input write_addr_strobe, flag_quadrant_strobe, write_queue_addr_bus,
    output almost_full_quadrant_bus, almost_full_quadrant_bus_oe_n,
    output active_almost_full_flag, active_full_flag, flag_bus_sync,
    output serial_program_done_n
  );

  modport writer (
    output write_chip_select_n, write_enable_n, write_data,
    output write_addr_strobe, flag_quadrant_strobe, write_queue_addr_bus,
    input almost_full_quadrant_bus, almost_full_quadrant_bus_oe_n,
    input active_almost_full_flag, active_full_flag, flag_bus_sync,
    input serial_program_done_n
  );
endinterface : wqs_write_if

// >>> hw/wqs_writer.sv
`timescale 1ns/1ps
module wqs_writer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Device link
  wqs_write_if.writer link,
  // Target device
  input wire logic [wqs_pkg::DEV_W-1:0] target_dev,
  // Word requests
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [wqs_pkg::QSEL_W-1:0] wr_queue,
  input wire logic [wqs_pkg::DATA_W-1:0] wr_data,
  // Quadrant requests
  input wire logic quad_req_valid,
  output logic quad_req_ready,
  input wire logic [wqs_pkg::QUAD_W-1:0] quad_req_sel,
  // Observed flag bus
  output logic flag_seen_valid,
  output logic flag_seen_sync,
  output logic [wqs_pkg::FLAG_W-1:0] flag_seen_bits
);
  import wqs_pkg::*;

  typedef enum logic [1:0] {
    WQS_WAIT,
    WQS_IDLE,
    WQS_SETTLE
  } wqs_wstate_t;

  wqs_wstate_t state_reg;
  logic [1:0] settle_reg;
  logic [QSEL_W-1:0] cur_q_reg;
  logic cur_vld_reg;
  logic need_sel;
  logic take_sel;
  logic take_quad;
  logic accept;

  assign need_sel = wr_valid && (!cur_vld_reg || wr_queue != cur_q_reg);
  assign take_quad = state_reg == WQS_IDLE && quad_req_valid;
  assign take_sel = state_reg == WQS_IDLE && !quad_req_valid && need_sel;
  assign quad_req_ready = take_quad;
  // One write in flight at a time so the full flag is always current
  assign wr_ready = state_reg == WQS_IDLE && !quad_req_valid && !need_sel &&
                    link.write_enable_n && !link.active_full_flag;
  assign accept = wr_valid && wr_ready;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= WQS_WAIT;
      settle_reg <= '0;
    end else begin
      unique case (state_reg)
        WQS_WAIT: begin
          if (!link.serial_program_done_n) begin
            state_reg <= WQS_IDLE;
          end
        end
        WQS_IDLE: begin
          if (take_sel) begin
            state_reg <= WQS_SETTLE;
            settle_reg <= 2'(SEL_GAP);
          end
        end
        WQS_SETTLE: begin
          if (settle_reg == 2'h1) begin
            state_reg <= WQS_IDLE;
          end else begin
            settle_reg <= settle_reg - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur_q_reg <= '0;
      cur_vld_reg <= 1'b0;
    end else if (take_sel) begin
      cur_q_reg <= wr_queue;
      cur_vld_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      link.write_addr_strobe <= 1'b0;
      link.flag_quadrant_strobe <= 1'b0;
      link.write_queue_addr_bus <= ADDR_RST;
    end else begin
      link.write_addr_strobe <= take_sel;
      link.flag_quadrant_strobe <= take_quad;
      if (take_sel) begin
        link.write_queue_addr_bus <= {target_dev, wr_queue};
      end else if (take_quad) begin
        link.write_queue_addr_bus <= {target_dev, 1'b0, quad_req_sel};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      link.write_chip_select_n <= 1'b1;
      link.write_enable_n <= 1'b1;
      link.write_data <= '0;
    end else begin
      link.write_chip_select_n <= state_reg == WQS_WAIT;
      link.write_enable_n <= !accept;
      if (accept) begin
        link.write_data <= wr_data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_seen_valid <= 1'b0;
      flag_seen_sync <= 1'b0;
      flag_seen_bits <= '0;
    end else begin
      flag_seen_valid <= !link.almost_full_quadrant_bus_oe_n;
      flag_seen_sync <= link.flag_bus_sync;
      flag_seen_bits <= link.almost_full_quadrant_bus;
    end
  end
endmodule : wqs_writer

// >>> testbench/test_write_port_queue_select.sv
`timescale 1ns/1ps
module test_write_port_queue_select;
  import wqs_pkg::*;
  localparam int PROG = 4;
  logic clk_sys;
  logic rst_n;
  logic flag_mode_polled;
  logic [DEV_W-1:0] chip_position_pins;
  logic [DEV_W-1:0] target_dev;
  logic exp_loop;
  logic rd_valid;
  logic rd_ready;
  logic [QSEL_W-1:0] rd_queue;
  logic [DATA_W-1:0] rd_data;
  logic wr_valid;
  logic wr_ready;
  logic [QSEL_W-1:0] wr_queue;
  logic [DATA_W-1:0] wr_data;
  logic quad_req_valid;
  logic quad_req_ready;
  logic [QUAD_W-1:0] quad_req_sel;
  logic flag_seen_valid;
  logic flag_seen_sync;
  logic [FLAG_W-1:0] flag_seen_bits;
  logic af;
  logic full_seen;
  logic done_n;
  int fails;
  int checks;

  wqs_write_if wqs_write_if_inst (.clk_sys(clk_sys));
  assign af = wqs_write_if_inst.active_almost_full_flag;
  assign full_seen = wqs_write_if_inst.active_full_flag;
  assign done_n = wqs_write_if_inst.serial_program_done_n;

  // Single device: token loops back to itself
  wqs_device #(.PROG_CYCLES(PROG)) wqs_device_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(wqs_write_if_inst),
    .flag_mode_polled(flag_mode_polled),
    .chip_position_pins(chip_position_pins),
    .expansion_flag_in(exp_loop), .expansion_flag_out(exp_loop),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_queue(rd_queue),
    .rd_data(rd_data));
  wqs_writer wqs_writer_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(wqs_write_if_inst),
    .target_dev(target_dev), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_queue(wr_queue), .wr_data(wr_data),
    .quad_req_valid(quad_req_valid), .quad_req_ready(quad_req_ready),
    .quad_req_sel(quad_req_sel), .flag_seen_valid(flag_seen_valid),
    .flag_seen_sync(flag_seen_sync), .flag_seen_bits(flag_seen_bits));
  wqs_link_properties wqs_link_properties_inst (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .write_chip_select_n(wqs_write_if_inst.write_chip_select_n),
    .write_enable_n(wqs_write_if_inst.write_enable_n),
    .write_addr_strobe(wqs_write_if_inst.write_addr_strobe),
    .flag_quadrant_strobe(wqs_write_if_inst.flag_quadrant_strobe),
    .almost_full_quadrant_bus_oe_n(
      wqs_write_if_inst.almost_full_quadrant_bus_oe_n),
    .active_full_flag(full_seen),
    .flag_bus_sync(wqs_write_if_inst.flag_bus_sync),
    .serial_program_done_n(done_n));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [DATA_W-1:0] word(input int k);
    return {8'hC3, 16'(k * 37), 8'h00, 8'(k)};
  endfunction : word

  task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bounded wait for a ready seen at a falling edge
  task automatic hs(input bit quad);
    int n;
    n = 0;
    @(negedge clk_sys);
    while ((quad ? quad_req_ready : wr_ready) !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    chk("ready", 0, n >= 300);
    @(posedge clk_sys);
  endtask : hs

  task automatic put(input logic [QSEL_W-1:0] q, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    wr_valid <= 1'b1;
    wr_queue <= q;
    wr_data <= d;
    hs(1'b0);
    wr_valid <= 1'b0;
  endtask : put

  task automatic quad(input logic [QUAD_W-1:0] s, input logic [7:0] exp,
                      input logic oe_exp);
    @(posedge clk_sys);
    quad_req_valid <= 1'b1;
    quad_req_sel <= s;
    hs(1'b1);
    quad_req_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("oe_n", oe_exp, wqs_write_if_inst.almost_full_quadrant_bus_oe_n);
    chk("seen valid", !oe_exp, flag_seen_valid);
    chk("quadrant", exp, flag_seen_bits);
  endtask : quad

  // Idle edge between pops stalls the drain side
  task automatic pop(input logic [QSEL_W-1:0] q, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    rd_ready <= 1'b1;
    @(negedge clk_sys);
    while (rd_valid !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    chk("rd_queue", q, rd_queue);
    chk("rd_data", d, rd_data);
    @(posedge clk_sys);
    rd_ready <= 1'b0;
  endtask : pop

  task automatic do_reset(input logic polled);
    int n;
    n = 0;
    rst_n <= 1'b0;
    flag_mode_polled <= polled;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk("done_n", 1, done_n);
    while (done_n !== 1'b0 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk("prog len", 1, n >= PROG - 2 && n <= PROG + 1);
  endtask : do_reset

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    $display("MISMATCH watchdog expected end seen timeout");
    close_out();
  end

  initial begin
    int n;
    {rst_n, flag_mode_polled, rd_ready, wr_valid, quad_req_valid} = 5'h00;
    {chip_position_pins, target_dev, wr_queue, quad_req_sel} = 15'h0000;
    wr_data = 40'h00_0000_0000;
    @(posedge clk_sys);
    do_reset(1'b0);
    // Fill four queues and the shared buffer, far side stalled
    for (int k = 0; k < 32; k++) begin
      put(QSEL_W'(k / 8), word(k));
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("af", (k % 8) >= QDEPTH_DEF - AF_GAP_DEF - 1, af);
      chk("full", (k % 8) == 7, full_seen);
    end
    for (int s = 0; s < 5; s++) begin
      quad(QUAD_W'(s), s == 0 ? 8'h0F : 8'h00, 1'b0);
    end
    for (int k = 0; k < 32; k++) pop(QSEL_W'(k / 8), word(k));
    @(negedge clk_sys);
    chk("full drained", 0, full_seen);
    put(5'h11, word(40));
    put(5'h03, word(41));
    put(5'h03, word(42));
    repeat (6) @(posedge clk_sys);
    target_dev <= 3'h1;
    put(5'h09, word(43));
    // Foreign id leaves the quadrant bus released
    quad(4'h0, 8'h00, 1'b1);
    repeat (6) @(posedge clk_sys);
    target_dev <= 3'h0;
    pop(5'h11, word(40));
    pop(5'h03, word(41));
    pop(5'h03, word(42));
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("foreign word", 0, rd_valid);
    @(posedge clk_sys);
    do_reset(1'b1);
    // Queue 0 reaches almost full so the polled quadrant carries a bit
    for (int k = 0; k < QDEPTH_DEF - AF_GAP_DEF; k++) begin
      put(5'h00, word(k));
    end
    repeat (4) @(posedge clk_sys);
    for (int p = 0; p < 2; p++) begin
      n = 0;
      while (flag_seen_sync !== 1'b1 && n < 30) begin
        @(negedge clk_sys);
        n++;
      end
      chk("poll gap", 1, n < 30);
      chk("poll bits", 8'h01, flag_seen_bits);
      // One cycle per quadrant plus one for the token hand-back
      if (p == 1) begin
        chk("poll period", NUM_Q_DEF / FLAG_W, n);
      end
      @(negedge clk_sys);
    end
    close_out();
  end
endmodule : test_write_port_queue_select

// >>> testbench/wqs_link_properties.sv
`timescale 1ns/1ps
module wqs_link_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Writer side
  input wire logic write_chip_select_n,
  input wire logic write_enable_n,
  input wire logic write_addr_strobe,
  input wire logic flag_quadrant_strobe,
  // Device side
  input wire logic almost_full_quadrant_bus_oe_n,
  input wire logic active_full_flag,
  input wire logic flag_bus_sync,
  input wire logic serial_program_done_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_strobes_apart: assert property (
    !(write_addr_strobe && flag_quadrant_strobe))
    else $error("both strobes in one cycle");
  a_strobe_one_cycle: assert property (
    write_addr_strobe |=> !write_addr_strobe)
    else $error("address strobe held high");
  a_select_write_gap: assert property (
    write_addr_strobe |-> write_enable_n ##1 write_enable_n)
    else $error("write too soon after select");
  a_no_early_select: assert property (
    serial_program_done_n |-> !write_addr_strobe && write_chip_select_n)
    else $error("selection before programming done");
  a_write_needs_cs: assert property (
    !write_enable_n |-> !write_chip_select_n)
    else $error("enable without chip select");
  a_write_spacing: assert property (
    !write_enable_n |=> write_enable_n)
    else $error("writes in adjacent cycles");
  a_sync_on_bus: assert property (
    flag_bus_sync |-> !almost_full_quadrant_bus_oe_n)
    else $error("sync while bus released");
  a_done_stays_low: assert property (
    !serial_program_done_n |=> !serial_program_done_n)
    else $error("done rose outside reset");
  a_reset_values: assert property (disable iff (1'b0)
    !rst_n |=> almost_full_quadrant_bus_oe_n && serial_program_done_n
      && write_chip_select_n && write_enable_n && !active_full_flag)
    else $error("outputs not at reset values");

  c_write: cover property (!write_enable_n);
  c_quad_strobe: cover property (flag_quadrant_strobe);
  c_sync: cover property (flag_bus_sync);
  c_full: cover property (active_full_flag);
endmodule : wqs_link_properties
